/* rtl/sstr_start_stop_tape_receiver.sv */
`timescale 1ns/100ps
`default_nettype none
module sstr_start_stop_tape_receiver
  import sstr_pkg::*;
#(
  parameter bit UNIVERSAL = 1'b1,
  parameter int POR_TICKS = POR_US,
  parameter int MAG_TICKS = MAG_US
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lineIn,
  input wire logic pickupIn,
  output logic [8:0] magnetOut,
  output logic xferPulse
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  sstr_rx_t rxState_r;
  logic [3:0] levels_r;
  logic [23:0] bitPer_r;
  logic [1:0] lineSync_r, pickSync_r;
  logic pickDly_r;
  logic [6:0] divCnt_r;
  logic usTick;
  logic [17:0] porCnt_r;
  logic porDone_r;
  logic [23:0] intCnt_r, oscCnt_r, gateCnt_r;
  logic ctrlReg_r, firstDone_r, signalGate_r, startTrig_r;
  logic advFirst, advData, advance;
  logic [7:0] sr_r, srNxt, storeReg_r;
  logic [8:0] postCnt_r;
  logic postRun_r, storeLoad_r, setOnes_r;
  logic xferPrime_r;
  logic [10:0] primeAge_r, vdlyCnt_r;
  logic vdlyRun_r;
  logic [12:0] magCnt_r;
  logic setupPh;
  // Level count kept inside the legal span; the basic build is fixed at five
  function automatic logic [3:0] clampLvl(input logic [3:0] v);
    return !UNIVERSAL ? LVL_MIN : (v < LVL_MIN) ? LVL_MIN : (v > LVL_MAX) ? LVL_MAX : v;
  endfunction
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // ----------------------------------------
  // Pin synchronisers and microsecond tick
  // ----------------------------------------
  // Line and pickup are asynchronous to ref_clk
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lineSync_r <= 2'h3;
      pickSync_r <= 2'h0;
      pickDly_r <= 1'b0;
    end else begin
      lineSync_r <= {lineSync_r[0], lineIn};
      pickSync_r <= {pickSync_r[0], pickupIn};
      pickDly_r <= pickSync_r[1];
    end
  end

  // Divider gives a one-cycle enable each microsecond
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      divCnt_r <= 7'h00;
    end else begin
      divCnt_r <= (divCnt_r == US_LAST) ? 7'h00 : divCnt_r + 7'h01;
    end
  end
  assign usTick = (divCnt_r == US_LAST);

  // Power-up hold; control stays cleared until it expires
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      porCnt_r <= 18'h00000;
      porDone_r <= 1'b0;
    end else if (!porDone_r && usTick) begin
      porCnt_r <= porCnt_r + 18'h00001;
      porDone_r <= (porCnt_r == 18'(POR_TICKS - 1));
    end
  end
  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Zero-wait: answer is registered in the setup cycle
  assign setupPh = psel && !penable && !pready;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setupPh;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (setupPh) begin
        case (paddr)
          ADDR_CTRL: prdata <= {28'h0000000, levels_r};
          ADDR_BITPER: prdata <= {8'h00, bitPer_r};
          ADDR_STATUS: prdata <= {16'h0000, sr_r, 4'h0, porDone_r, signalGate_r, xferPrime_r, ctrlReg_r};
          ADDR_STORE: prdata <= {24'h000000, storeReg_r};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Writes land at the edge where pready is sampled high
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      levels_r <= LVL_RST;
      bitPer_r <= BITPER_RST;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        levels_r <= clampLvl(pwdata[CTRL_LVL_LSB +: 4]);
      end
      if (paddr == ADDR_BITPER) begin
        bitPer_r <= (pwdata[23:0] < 24'h000002) ? 24'h000002 : pwdata[23:0];
      end
    end
  end
  property p_lvlRange;
    levels_r >= LVL_MIN && levels_r <= LVL_MAX;
  endproperty
  a_lvlRange: assert property (p_lvlRange) else $error("level count out of range");
  // ----------------------------------------
  // Start detection
  // ----------------------------------------
  // Integrator: any mark resets the count, so short hits never
  // reach half a bit and cannot trigger a false start
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      intCnt_r <= 24'h000000;
      startTrig_r <= 1'b0;
    end else begin
      startTrig_r <= 1'b0;
      if (rxState_r != RX_IDLE || !signalGate_r || !porDone_r || lineSync_r[1]) begin
        intCnt_r <= 24'h000000;
      end else if (intCnt_r == {1'b0, bitPer_r[23:1]}) begin
        startTrig_r <= 1'b1;
        intCnt_r <= 24'h000000;
      end else begin
        intCnt_r <= intCnt_r + 24'h000001;
      end
    end
  end
  property p_startLow;
    startTrig_r |-> !$past(lineSync_r[1], 1) && !$past(lineSync_r[1], 2);
  endproperty
  a_startLow: assert property (p_startLow) else $error("start without space on line");
  // ----------------------------------------
  // Gated bit-rate oscillator and advance pulses
  // ----------------------------------------
  // Bit period must exceed the 50 us first-advance delay
  always_ff @(posedge ref_clk) begin
    if (srst || !ctrlReg_r) begin
      oscCnt_r <= 24'h000000;
      firstDone_r <= 1'b0;
    end else begin
      oscCnt_r <= advData ? 24'h000000 : oscCnt_r + 24'h000001;
      if (advFirst) begin
        firstDone_r <= 1'b1;
      end
    end
  end
  assign advFirst = ctrlReg_r && !firstDone_r && (oscCnt_r == FIRST_CYC);
  assign advData = ctrlReg_r && (oscCnt_r == bitPer_r - 24'h000001);
  assign advance = advFirst || advData;
  property p_oscOff;
    !ctrlReg_r && !$past(ctrlReg_r) |-> oscCnt_r == 24'h000000 && !advance;
  endproperty
  a_oscOff: assert property (p_oscOff) else $error("oscillator running while control clear");

  // Shift toward element 1; element N takes zero first, then the line
  always_comb begin
    srNxt = 8'hFF;
    for (int i = 0; i < 8; i++) begin
      if (i == int'(levels_r) - 1) begin
        srNxt[i] = advFirst ? 1'b0 : lineSync_r[1];
      end else if (i < int'(levels_r) - 1) begin
        srNxt[i] = sr_r[i + 1];
      end
    end
  end

  // Signal register; set pulse returns it to all ones
  always_ff @(posedge ref_clk) begin
    if (srst || setOnes_r) begin
      sr_r <= 8'hFF;
    end else if (advance) begin
      sr_r <= srNxt;
    end
  end
  property p_setOnes;
    setOnes_r |=> sr_r == 8'hFF && xferPrime_r;
  endproperty
  a_setOnes: assert property (p_setOnes) else $error("set pulse did not restore ones");
  // ----------------------------------------
  // Control register and receiver sequence
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst || !porDone_r) begin
      ctrlReg_r <= 1'b0;
      rxState_r <= RX_IDLE;
    end else begin
      case (rxState_r)
        RX_IDLE: begin
          if (startTrig_r) begin
            ctrlReg_r <= 1'b1;
            rxState_r <= RX_RUN;
          end
        end
        RX_RUN: begin
          // Start zero leaving element 1 clears control
          if (advance && !sr_r[0]) begin
            ctrlReg_r <= 1'b0;
            rxState_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (signalGate_r) begin
            rxState_r <= RX_IDLE;
          end
        end
        default: rxState_r <= RX_IDLE;
      endcase
    end
  end
  property p_idleGate;
    rxState_r == RX_IDLE && porDone_r |-> signalGate_r && !ctrlReg_r;
  endproperty
  a_idleGate: assert property (p_idleGate) else $error("idle state not as expected");
  property p_trigSets;
    startTrig_r && rxState_r == RX_IDLE |=> ctrlReg_r;
  endproperty
  a_trigSets: assert property (p_trigSets) else $error("trigger did not set control");
  property p_clearCause;
    $fell(ctrlReg_r) && porDone_r |-> $past(advance) && !$past(sr_r[0]) && !signalGate_r;
  endproperty
  a_clearCause: assert property (p_clearCause) else $error("control cleared without start zero");
  // Stop-time synchroniser closes the signal gate for one bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      signalGate_r <= 1'b1;
      gateCnt_r <= 24'h000000;
    end else if (rxState_r == RX_RUN && advance && !sr_r[0]) begin
      signalGate_r <= 1'b0;
      gateCnt_r <= bitPer_r;
    end else if (!signalGate_r) begin
      gateCnt_r <= gateCnt_r - 24'h000001;
      if (gateCnt_r == 24'h000001) begin
        signalGate_r <= 1'b1;
      end
    end
  end

  // Shift delay and set-one delay run from the last advance
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      postRun_r <= 1'b0;
      postCnt_r <= 9'h000;
      storeLoad_r <= 1'b0;
      setOnes_r <= 1'b0;
    end else begin
      storeLoad_r <= 1'b0;
      setOnes_r <= 1'b0;
      if (rxState_r == RX_RUN && advance && !sr_r[0]) begin
        postRun_r <= 1'b1;
        postCnt_r <= 9'h000;
      end else if (postRun_r && usTick) begin
        postCnt_r <= postCnt_r + 9'h001;
        if (postCnt_r == 9'(T_SHIFT_US - 1)) begin
          storeLoad_r <= 1'b1;
        end
        if (postCnt_r == 9'(T_SET1_US - 1)) begin
          setOnes_r <= 1'b1;
          postRun_r <= 1'b0;
        end
      end
    end
  end

  // Storage keeps its word while the next one is assembled
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      storeReg_r <= 8'h00;
    end else if (storeLoad_r) begin
      storeReg_r <= sr_r & ~(8'hFF << levels_r);
    end
  end
  property p_storeLoad;
    storeLoad_r |=> storeReg_r == ($past(sr_r) & ~(8'hFF << $past(levels_r)));
  endproperty
  a_storeLoad: assert property (p_storeLoad) else $error("storage not loaded from shift register");
  // ----------------------------------------
  // Punch transfer
  // ----------------------------------------
  // Set pulse wins over a transfer in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      xferPrime_r <= 1'b1;
    end else if (setOnes_r) begin
      xferPrime_r <= 1'b1;
    end else if (xferPulse) begin
      xferPrime_r <= 1'b0;
    end
  end

  // Longer prime presence shortens the pickup delay
  always_ff @(posedge ref_clk) begin
    if (srst || !xferPrime_r) begin
      primeAge_r <= 11'h000;
    end else if (usTick && primeAge_r != 11'(VMAX_US - VMIN_US)) begin
      primeAge_r <= primeAge_r + 11'h001;
    end
  end

  // Variable delay from pickup to transfer pulse
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      vdlyRun_r <= 1'b0;
      vdlyCnt_r <= 11'h000;
      xferPulse <= 1'b0;
    end else begin
      xferPulse <= 1'b0;
      if (pickSync_r[1] && !pickDly_r && !vdlyRun_r) begin
        vdlyRun_r <= 1'b1;
        vdlyCnt_r <= 11'(VMAX_US) - primeAge_r;
      end else if (vdlyRun_r && usTick) begin
        vdlyCnt_r <= vdlyCnt_r - 11'h001;
        if (vdlyCnt_r == 11'h001) begin
          vdlyRun_r <= 1'b0;
          xferPulse <= xferPrime_r;
        end
      end
    end
  end
  property p_xferPrimed;
    xferPulse |-> $past(xferPrime_r);
  endproperty
  a_xferPrimed: assert property (p_xferPrimed) else $error("transfer without prime");
  // Feed always fires; code magnets follow storage ones
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      magnetOut <= 9'h000;
      magCnt_r <= 13'h0000;
    end else if (xferPulse) begin
      magnetOut <= {storeReg_r, 1'b1};
      magCnt_r <= 13'(MAG_TICKS);
    end else if (magCnt_r != 13'h0000 && usTick) begin
      magCnt_r <= magCnt_r - 13'h0001;
      if (magCnt_r == 13'h0001) begin
        magnetOut <= 9'h000;
      end
    end
  end
  property p_feed;
    xferPulse |=> magnetOut == {$past(storeReg_r), 1'b1};
  endproperty
  a_feed: assert property (p_feed) else $error("magnets not fired from storage");

endmodule // sstr_start_stop_tape_receiver
`default_nettype wire

/* rtl/sstr_pkg.sv */
`default_nettype none
package sstr_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int US_CYC = CLK_HZ / 1_000_000;
  localparam int T_FIRST_US = 50;
  localparam int T_SHIFT_US = 100;
  localparam int T_SET1_US = 200;
  localparam real T_VMIN_MS = 0.4;
  localparam real T_VMAX_MS = 1.2;
  localparam real T_MAG_MS = 4.5;
  localparam int T_POR_MS = 200;
  localparam int VMIN_US = int'(T_VMIN_MS * 1000.0);
  localparam int VMAX_US = int'(T_VMAX_MS * 1000.0);
  localparam int MAG_US = int'(T_MAG_MS * 1000.0);
  localparam int POR_US = T_POR_MS * 1000;
  localparam logic [23:0] FIRST_CYC = 24'(T_FIRST_US * US_CYC);
  localparam logic [6:0] US_LAST = 7'(US_CYC - 1);

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BITPER = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_STORE = 8'h0C;
  localparam int CTRL_LVL_LSB = 0;
  localparam logic [3:0] LVL_RST = 4'h5;
  localparam logic [3:0] LVL_MIN = 4'h5;
  localparam logic [3:0] LVL_MAX = 4'h8;
  localparam logic [23:0] BITPER_RST = 24'h002710;
  localparam int ST_CTRL = 0;
  localparam int ST_PRIME = 1;
  localparam int ST_GATE = 2;
  localparam int ST_POR = 3;
  localparam int ST_SR_LSB = 8;

  // ----------------------------------------
  // Receiver states
  // ----------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_RUN, RX_STOP} sstr_rx_t;

endpackage
`default_nettype wire

/* dv/sstr_far_end.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Far side: data set line and tape punch
// ----------------------------------------
module sstr_far_end (
  input wire logic ref_clk,
  output logic lineIn,
  output logic pickupIn
);
  // Line rests at mark, pickup rests low
  initial begin
    lineIn = 1'b1;
    pickupIn = 1'b0;
  end

  // Start space, data bits LSB first, one stop mark; called just after an edge
  task automatic sendChar(input int lvls, input logic [7:0] d, input int per);
    lineIn <= 1'b0;
    repeat (per) @(posedge ref_clk);
    for (int i = 0; i < lvls; i++) begin
      lineIn <= d[i];
      repeat (per) @(posedge ref_clk);
    end
    lineIn <= 1'b1;
    repeat (per) @(posedge ref_clk);
  endtask

  // Short space hit, far below half a bit, so it must not start a character
  task automatic noiseHit(input int len);
    lineIn <= 1'b0;
    repeat (len) @(posedge ref_clk);
    lineIn <= 1'b1;
    @(posedge ref_clk);
  endtask

  // One pickup per punch cycle; a real punch fires once inside each character interval
  task automatic pickup();
    pickupIn <= 1'b1;
    repeat (100) @(posedge ref_clk);
    pickupIn <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule // sstr_far_end
`default_nettype wire

/* dv/tb_start_stop_tape_receiver.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_start_stop_tape_receiver
  import sstr_pkg::*;
;
  // Bit period must exceed the 50 us first-advance delay
  localparam int PER = 5200;
  localparam int MAG = 20;
  localparam logic [7:0] CHAR = 8'hA5;
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, lineIn, pickupIn, xferPulse, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] magnetOut;
  int nMismatch = 0;
  int checkCount = 0;
  int cycleCount = 0;
  int n;

  sstr_start_stop_tape_receiver #(.UNIVERSAL(1'b1), .POR_TICKS(5), .MAG_TICKS(MAG)) uut (
    .ref_clk(ref_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lineIn(lineIn), .pickupIn(pickupIn), .magnetOut(magnetOut), .xferPulse(xferPulse));
  sstr_far_end far (.ref_clk(ref_clk), .lineIn(lineIn), .pickupIn(pickupIn));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Bench tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // APB transfer; no wait count assumed, only the global timeout ends a hang
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(nm, exp, rd & m);
  endtask

  task automatic testDone();
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Prime age reaches only about 687 of 800 by the pickup, so the delay is about 513 us (51k cycles) and the transfer lands near 120k cycles; margin above that
  always @(posedge ref_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 150000) begin
      nMismatch++;
      $display("[FAIL] runTime expected done seen timeout");
      testDone();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    paddr = 8'h00;
    pwrite = 1'b0;
    pwdata = 32'h0;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rdChk("porEarly", ADDR_STATUS, 32'h8, 32'h0);
    rdChk("ctrlReset", ADDR_CTRL, 32'hF, {28'h0, LVL_RST});
    rdChk("bitperReset", ADDR_BITPER, 32'hFFFFFF, {8'h0, BITPER_RST});
    apb(ADDR_CTRL, 1'b1, 32'h9);
    rdChk("lvlClampHi", ADDR_CTRL, 32'hF, 32'h8);
    apb(ADDR_CTRL, 1'b1, 32'h3);
    rdChk("lvlClampLo", ADDR_CTRL, 32'hF, 32'h5);
    apb(8'h10, 1'b0, 32'h0);
    chk("unmappedErr", 32'h1, {31'h0, err});
    chk("unmappedData", 32'h0, rd);
    apb(ADDR_CTRL, 1'b1, 32'h8);
    apb(ADDR_BITPER, 1'b1, 32'(PER));
    rdChk("bitper", ADDR_BITPER, 32'hFFFFFF, 32'(PER));
    $display("test registers done");
    // Idle state, then a noise hit that must be rejected
    repeat (600) @(posedge ref_clk);
    rdChk("idle", ADDR_STATUS, 32'hF, 32'hE);
    far.noiseHit(100);
    repeat (3000) @(posedge ref_clk);
    rdChk("noiseReject", ADDR_STATUS, 32'h1, 32'h0);
    $display("test idle done");
    // Eight-level character; control must set only after half a bit
    fork
      far.sendChar(8, CHAR, PER);
      begin
        repeat (PER / 2 - 100) @(posedge ref_clk);
        rdChk("ctrlEarly", ADDR_STATUS, 32'h1, 32'h0);
        repeat (200) @(posedge ref_clk);
        rdChk("ctrlSet", ADDR_STATUS, 32'h1, 32'h1);
        repeat (PER * 3) @(posedge ref_clk);
        rdChk("ctrlRun", ADDR_STATUS, 32'h1, 32'h1);
        // Just past the last advance: control clear, gate closed, storage not yet loaded
        repeat (PER * 5) @(posedge ref_clk);
        rdChk("stopGate", ADDR_STATUS, 32'h5, 32'h0);
        rdChk("storeHeld", ADDR_STORE, 32'hFF, 32'h0);
      end
    join
    repeat (13000) @(posedge ref_clk);
    rdChk("store", ADDR_STORE, 32'hFF, {24'h0, CHAR});
    rdChk("rearmed", ADDR_STATUS, 32'hFF0F, 32'hFF0E);
    $display("test receive done");
    // Punch cycle: pickup, delayed transfer, magnets
    far.pickup();
    n = 100;
    while (xferPulse !== 1'b1) begin
      @(posedge ref_clk);
      n++;
    end
    chk("xferDelayOk", 32'h1, {31'h0, (n >= 40000 && n <= 120300)});
    @(posedge ref_clk);
    chk("magnets", {23'h0, CHAR, 1'b1}, {23'h0, magnetOut});
    n = 0;
    while (magnetOut !== 9'h0) begin
      @(posedge ref_clk);
      n++;
    end
    chk("magnetHoldOk", 32'h1, {31'h0, (n >= MAG * US_CYC - 100 && n <= MAG * US_CYC + 100)});
    rdChk("primeCleared", ADDR_STATUS, 32'h2, 32'h0);
    $display("test punch done");
    testDone();
  end
endmodule // tb_start_stop_tape_receiver
`default_nettype wire
